/* File: timer0_capture.sv */
// timer 0 with prescaler, capture pairs and port-7 edge interrupt logic
// Operation
// - fourth irq edges: none, fall, rise, both
// - third irq edges decoded the same way
// - fourth flag sets; flag and enable request
// - third flag and enable: request and hold release
// - flags cleared only by software write
// - hold blocks third-pin edge matching latched pin level
// - high capture from second irq or fourth
// - low capture from first irq or third
// - base clock: subclock, cycle clock, prescaler
// - filter constant one, 128 or 32 cycles
// - count pulses from fourth or third pin
// - second-bank capture assignment overrides port-7
// - mode 0: two prescaled 8-bit timers
// - mode 1: low counts pulses, high timer
// - mode 2: prescaled 16-bit timer
// - mode 3: 16-bit external pulse counter
// - 8-bit modes capture each byte separately
// - 16-bit modes capture both bytes together
// - byte interrupt each period when enabled
// - prescaler matches, restarts on match or write
// - bytes zero when stopped or matched
// - match buffers track when stopped, reload on match
// - length bit joins bytes, ext bit clocks low
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "timer0_cfg.svh"

module timer0_capture #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // port pins and detection pulses from neighbouring logic
    input wire logic PORT_PIN_C_I,
    input wire logic PORT_PIN_D_I,
    input wire logic FIRST_EXT_IRQ_DET_I,
    input wire logic SECOND_EXT_IRQ_DET_I,
    input wire logic BANK2_IRQ_A_DET_I,
    input wire logic BANK2_IRQ_B_DET_I,
    input wire logic BANK2_LCAP_ASSIGN_I,
    input wire logic BANK2_LCAP_DET_I,
    input wire logic BANK2_HCAP_ASSIGN_I,
    input wire logic BANK2_HCAP_DET_I,
    // system state
    input wire logic HOLD_I,
    input wire logic SUBCLK_EN_I,
    // requests and derived controls
    output logic IRQ3_REQ_O,
    output logic IRQ2_REQ_O,
    output logic HOLD_RELEASE_O,
    output logic TIMER_LOW_REQ_O,
    output logic TIMER_HIGH_REQ_O,
    output logic BASE_CLK_EN_O,
    output logic BUZZER_SELECT_O,
    output logic [7:0] FILTER_CYCLES_O
);

    // edge match for a rise/fall select pair
    function automatic logic edge_hit(input logic rise_sel, input logic fall_sel,
                                      input logic rise, input logic fall);
        edge_hit = (rise_sel & rise) | (fall_sel & fall);
    endfunction

    // registers
    timer0_pkg::tctl_s ctrl_q, ctrl_d;
    logic [7:0] prr_q;
    logic [7:0] pre_q, pre_d;
    logic [7:0] cnt_l_q, cnt_l_d, cnt_h_q, cnt_h_d;
    logic [7:0] mreg_l_q, mreg_h_q;
    logic [7:0] buf_l_q, buf_l_d, buf_h_q, buf_h_d;
    logic [7:0] cap0_l_q, cap0_l_d, cap0_h_q, cap0_h_d;
    logic [7:0] cap1_l_q, cap1_l_d, cap1_h_q, cap1_h_d;
    logic [7:0] sel_q;
    logic [7:0] eic_q, eic_d;
    logic [1:0] pin_sync_q [SYNC_STAGES];
    logic [1:0] pin_prev_q;
    logic hold_q;
    logic hold_lat_q;
    timer0_pkg::bus_req_s req_q;

    // bus decode
    wire addr_valid = HSEL_I & HREADY_I & HTRANS_I[1];
    wire [15:0] wr_idx = req_q.idx;
    wire [7:0] wdata = HWDATA_I[7:0];
    wire wr_ctrl = req_q.wr & (wr_idx == `IDX_TIMER_CONTROL);
    wire wr_prr = req_q.wr & (wr_idx == `IDX_PRESCALER_MATCH);
    wire wr_ml = req_q.wr & (wr_idx == `IDX_MATCH_LOW);
    wire wr_mh = req_q.wr & (wr_idx == `IDX_MATCH_HIGH);
    wire wr_sel = req_q.wr & (wr_idx == `IDX_INPUT_SELECT);
    wire wr_eic = req_q.wr & (wr_idx == `IDX_EDGE_IRQ_CONTROL);

    // synchronised pins; index 0 is pin c, index 1 is pin d
    wire [1:0] pin_s = pin_sync_q[SYNC_STAGES-1];
    wire [1:0] rise = pin_s & ~pin_prev_q;
    wire [1:0] fall = ~pin_s & pin_prev_q;

    // hold entry latches pin c; blocked edges cannot wake the part
    wire hold_rise_ok = ~(HOLD_I & hold_lat_q);
    wire hold_fall_ok = ~(HOLD_I & ~hold_lat_q);
    wire irq2_det = edge_hit(eic_q[`EIC_IRQ2_RISE], eic_q[`EIC_IRQ2_FALL],
                             rise[0] & hold_rise_ok, fall[0] & hold_fall_ok);
    wire irq3_det = edge_hit(eic_q[`EIC_IRQ3_RISE], eic_q[`EIC_IRQ3_FALL],
                             rise[1], fall[1]);

    // capture and count sources
    wire p7_lcap = sel_q[`SEL_LCAP_SEL] ? FIRST_EXT_IRQ_DET_I : irq2_det;
    wire p7_hcap = sel_q[`SEL_HCAP_SEL] ? SECOND_EXT_IRQ_DET_I : irq3_det;
    wire lcap_evt = BANK2_LCAP_ASSIGN_I ? BANK2_LCAP_DET_I : p7_lcap;
    wire hcap_evt = BANK2_HCAP_ASSIGN_I ? BANK2_HCAP_DET_I : p7_hcap;
    wire cnt_evt = sel_q[`SEL_COUNT_SEL] ? irq3_det : irq2_det;

    // mode and clocks; the prescaler halts in hold
    wire [1:0] mode_bits = {ctrl_q.join_16bit, ctrl_q.low_ext_clock};
    timer0_pkg::mode_e mode;
    assign mode = timer0_pkg::mode_e'(mode_bits);
    wire pre_match = ~HOLD_I & (pre_q == prr_q);
    wire tick_l = mode[0] ? cnt_evt : pre_match;
    wire tick_h = pre_match;
    wire joined = ctrl_q.join_16bit;
    wire run_l = ctrl_q.low_run;
    wire run_h = ctrl_q.high_run;

    // match signals; the joined counter needs all 16 bits equal
    wire match16 = joined & tick_l & run_l & run_h &
                   ({cnt_h_q, cnt_l_q} == {buf_h_q, buf_l_q});
    wire match_l8 = ~joined & tick_l & run_l & (cnt_l_q == buf_l_q);
    wire match_h8 = ~joined & tick_h & run_h & (cnt_h_q == buf_h_q);
    wire match_l = match16 | match_l8;
    wire match_h = match16 | match_h8;
    wire [15:0] cnt16_inc = {cnt_h_q, cnt_l_q} + 16'h0001;

    // prescaler restarts on its match or on a write to its match value
    always_comb begin
        if (wr_prr | pre_match) begin
            pre_d = 8'h00;
        end else if (HOLD_I) begin
            pre_d = pre_q;
        end else begin
            pre_d = pre_q + 8'h01;
        end
    end

    // counter bytes; a stopped byte sits at zero
    always_comb begin
        cnt_l_d = cnt_l_q;
        cnt_h_d = cnt_h_q;
        if (joined) begin
            if (match16) begin
                cnt_l_d = 8'h00;
                cnt_h_d = 8'h00;
            end else if (tick_l & run_l & run_h) begin
                cnt_l_d = cnt16_inc[7:0];
                cnt_h_d = cnt16_inc[15:8];
            end
        end else begin
            if (match_l8) begin
                cnt_l_d = 8'h00;
            end else if (tick_l & run_l) begin
                cnt_l_d = cnt_l_q + 8'h01;
            end
            if (match_h8) begin
                cnt_h_d = 8'h00;
            end else if (tick_h & run_h) begin
                cnt_h_d = cnt_h_q + 8'h01;
            end
        end
        if (!run_l) begin
            cnt_l_d = 8'h00;
        end
        if (!run_h) begin
            cnt_h_d = 8'h00;
        end
    end

    // match buffers follow the reload value unless running
    always_comb begin
        buf_l_d = buf_l_q;
        buf_h_d = buf_h_q;
        if (!run_l | match_l) begin
            buf_l_d = mreg_l_q;
        end
        if (!run_h | match_h) begin
            buf_h_d = mreg_h_q;
        end
    end

    // captures read the pre-update count, so a same-cycle step is not seen
    always_comb begin
        cap0_l_d = cap0_l_q;
        cap0_h_d = cap0_h_q;
        cap1_l_d = cap1_l_q;
        cap1_h_d = cap1_h_q;
        if (joined) begin
            if (hcap_evt) begin
                cap0_l_d = cnt_l_q;
                cap0_h_d = cnt_h_q;
            end
            if (BANK2_IRQ_B_DET_I) begin
                cap1_l_d = cnt_l_q;
                cap1_h_d = cnt_h_q;
            end
        end else begin
            if (lcap_evt) begin
                cap0_l_d = cnt_l_q;
            end
            if (BANK2_IRQ_A_DET_I) begin
                cap1_l_d = cnt_l_q;
            end
            if (hcap_evt) begin
                cap0_h_d = cnt_h_q;
            end
            if (BANK2_IRQ_B_DET_I) begin
                cap1_h_d = cnt_h_q;
            end
        end
    end

    // control register: software writes, match flags set with priority
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = timer0_pkg::tctl_s'(wdata);
        end
        ctrl_d.low_cmp = ctrl_d.low_cmp | match_l;
        ctrl_d.high_cmp = ctrl_d.high_cmp | match_h;
    end

    // edge flags stay set until software writes a zero; a new edge wins
    always_comb begin
        eic_d = eic_q;
        if (wr_eic) begin
            eic_d = wdata;
        end
        eic_d[`EIC_IRQ3_FLAG] = eic_d[`EIC_IRQ3_FLAG] | irq3_det;
        eic_d[`EIC_IRQ2_FLAG] = eic_d[`EIC_IRQ2_FLAG] | irq2_det;
    end

    // pin synchronisers; only the last stage feeds edge detection
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                pin_sync_q[i] <= 2'h0;
            end
        end else begin
            pin_sync_q[0] <= {PORT_PIN_D_I, PORT_PIN_C_I};
            for (int i = 1; i < SYNC_STAGES; i++) begin
                pin_sync_q[i] <= pin_sync_q[i-1];
            end
        end
    end

    // edge history and hold entry latch
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            pin_prev_q <= 2'h0;
            hold_q <= 1'b0;
            hold_lat_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_s;
            hold_q <= HOLD_I;
            if (HOLD_I & ~hold_q) begin
                hold_lat_q <= pin_s[0];
            end
        end
    end

    // bus address phase capture
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            req_q <= '0;
        end else if (HREADY_I) begin
            req_q.wr <= addr_valid & HWRITE_I;
            req_q.rd <= addr_valid & ~HWRITE_I;
            req_q.idx <= HADDR_I[17:2];
        end
    end

    // software-written registers
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            prr_q <= `REG_RESET;
            mreg_l_q <= `REG_RESET;
            mreg_h_q <= `REG_RESET;
            sel_q <= `REG_RESET;
        end else begin
            if (wr_prr) begin
                prr_q <= wdata;
            end
            if (wr_ml) begin
                mreg_l_q <= wdata;
            end
            if (wr_mh) begin
                mreg_h_q <= wdata;
            end
            if (wr_sel) begin
                sel_q <= wdata;
            end
        end
    end

    // timer state
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_q <= timer0_pkg::tctl_s'(`REG_RESET);
            eic_q <= `REG_RESET;
            pre_q <= 8'h00;
            cnt_l_q <= 8'h00;
            cnt_h_q <= 8'h00;
            buf_l_q <= 8'h00;
            buf_h_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            eic_q <= eic_d;
            pre_q <= pre_d;
            cnt_l_q <= cnt_l_d;
            cnt_h_q <= cnt_h_d;
            buf_l_q <= buf_l_d;
            buf_h_q <= buf_h_d;
        end
    end

    // capture registers; cleared at reset so reads are defined
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cap0_l_q <= 8'h00;
            cap0_h_q <= 8'h00;
            cap1_l_q <= 8'h00;
            cap1_h_q <= 8'h00;
        end else begin
            cap0_l_q <= cap0_l_d;
            cap0_h_q <= cap0_h_d;
            cap1_l_q <= cap1_l_d;
            cap1_h_q <= cap1_h_d;
        end
    end

    // read mux from the held address; unmapped reads return zero
    logic [7:0] rd_byte;
    always_comb begin
        case (req_q.idx)
            `IDX_TIMER_CONTROL: rd_byte = ctrl_q;
            `IDX_PRESCALER_MATCH: rd_byte = prr_q;
            `IDX_COUNT_LOW: rd_byte = cnt_l_q;
            `IDX_COUNT_HIGH: rd_byte = cnt_h_q;
            `IDX_MATCH_LOW: rd_byte = mreg_l_q;
            `IDX_MATCH_HIGH: rd_byte = mreg_h_q;
            `IDX_CAPTURE0_LOW: rd_byte = cap0_l_q;
            `IDX_CAPTURE0_HIGH: rd_byte = cap0_h_q;
            `IDX_CAPTURE1_LOW: rd_byte = cap1_l_q;
            `IDX_CAPTURE1_HIGH: rd_byte = cap1_h_q;
            `IDX_EDGE_IRQ_CONTROL: rd_byte = eic_q;
            `IDX_INPUT_SELECT: rd_byte = sel_q;
            default: rd_byte = 8'h00;
        endcase
    end

    // zero-wait slave, always okay
    assign HRDATA_O = req_q.rd ? {24'h000000, rd_byte} : 32'h00000000;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    // interrupt requests are levels while flag and enable are both set
    assign IRQ3_REQ_O = eic_q[`EIC_IRQ3_FLAG] & eic_q[`EIC_IRQ3_EN];
    assign IRQ2_REQ_O = eic_q[`EIC_IRQ2_FLAG] & eic_q[`EIC_IRQ2_EN];
    assign HOLD_RELEASE_O = IRQ2_REQ_O;
    assign TIMER_LOW_REQ_O = ctrl_q.low_cmp & ctrl_q.low_ie;
    assign TIMER_HIGH_REQ_O = ctrl_q.high_cmp & ctrl_q.high_ie;

    // base timer clock enable; subclock rate comes in as an enable pulse
    wire [1:0] bclk_sel = {sel_q[`SEL_BCLK_HI], sel_q[`SEL_BCLK_LO]};
    always_comb begin
        case (bclk_sel)
            2'h1: BASE_CLK_EN_O = 1'b1;
            2'h3: BASE_CLK_EN_O = pre_match;
            default: BASE_CLK_EN_O = SUBCLK_EN_I;
        endcase
    end

    // noise filter constant for the pin filters elsewhere
    wire [1:0] filt_sel = {sel_q[`SEL_FILTER_SEL], sel_q[`SEL_FILTER_ON]};
    always_comb begin
        case (filt_sel)
            2'h1: FILTER_CYCLES_O = `FILTER_LONG;
            2'h3: FILTER_CYCLES_O = `FILTER_MID;
            default: FILTER_CYCLES_O = `FILTER_SHORT;
        endcase
    end

    assign BUZZER_SELECT_O = sel_q[`SEL_BUZZER];

endmodule

/* File: timer0_cfg.svh */
// register indices, field positions, reset values and counts for timer 0
`ifndef TIMER0_CFG_SVH
`define TIMER0_CFG_SVH

// register indices; byte address is four times the index
`define IDX_TIMER_CONTROL 16'hfe10
`define IDX_PRESCALER_MATCH 16'hfe11
`define IDX_COUNT_LOW 16'hfe12
`define IDX_COUNT_HIGH 16'hfe13
`define IDX_MATCH_LOW 16'hfe14
`define IDX_MATCH_HIGH 16'hfe15
`define IDX_CAPTURE0_LOW 16'hfe16
`define IDX_CAPTURE0_HIGH 16'hfe17
`define IDX_CAPTURE1_LOW 16'hfe1e
`define IDX_CAPTURE1_HIGH 16'hfe1f
`define IDX_EDGE_IRQ_CONTROL 16'hfe5e
`define IDX_INPUT_SELECT 16'hfe5f

// edge_interrupt_control fields
`define EIC_IRQ3_RISE 7
`define EIC_IRQ3_FALL 6
`define EIC_IRQ3_FLAG 5
`define EIC_IRQ3_EN 4
`define EIC_IRQ2_RISE 3
`define EIC_IRQ2_FALL 2
`define EIC_IRQ2_FLAG 1
`define EIC_IRQ2_EN 0

// input_select fields
`define SEL_HCAP_SEL 7
`define SEL_LCAP_SEL 6
`define SEL_BCLK_HI 5
`define SEL_BCLK_LO 4
`define SEL_BUZZER 3
`define SEL_FILTER_SEL 2
`define SEL_FILTER_ON 1
`define SEL_COUNT_SEL 0

// reset value shared by all writable registers
`define REG_RESET 8'h00

// noise filter time constants in cycles
`define FILTER_SHORT 8'h01
`define FILTER_LONG 8'h80
`define FILTER_MID 8'h20

`endif

/* File: timer0_pkg.sv */
// types shared by the timer 0 design
package timer0_pkg;

    // operating mode from the length and external-clock bits
    typedef enum logic [1:0] {
        MODE_TIMER8,
        MODE_COUNT8,
        MODE_TIMER16,
        MODE_COUNT16
    } mode_e;

    // timer_control register as a carrier
    typedef struct packed {
        logic high_run;
        logic low_run;
        logic join_16bit;
        logic low_ext_clock;
        logic high_cmp;
        logic high_ie;
        logic low_cmp;
        logic low_ie;
    } tctl_s;

    // ahb address phase held into the data phase
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] idx;
    } bus_req_s;

endpackage

/* File: timer0_capture_props.sv */
// assertion checker for the timer 0 block ports
`timescale 1ns/100ps
`include "timer0_cfg.svh"
module timer0_capture_props #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    // bus
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // pins and controls
    input wire logic PORT_PIN_D_I,
    input wire logic HOLD_I,
    input wire logic IRQ3_REQ_O,
    input wire logic IRQ2_REQ_O,
    input wire logic HOLD_RELEASE_O,
    input wire logic TIMER_LOW_REQ_O,
    input wire logic BASE_CLK_EN_O,
    input wire logic [7:0] FILTER_CYCLES_O
);
    // pin path: sync stages plus edge detect and flag
    localparam int PIN_LAT = SYNC_STAGES + 2;
    logic act_q;
    logic wr_q;
    logic [15:0] idx_q;
    logic [7:0] eic_q;
    // decode of the data phase that is now in progress
    wire taken = HSEL_I && HREADY_I && HTRANS_I[1];
    wire wr_sel = act_q && wr_q && idx_q == `IDX_INPUT_SELECT;
    wire wr_eic = act_q && wr_q && idx_q == `IDX_EDGE_IRQ_CONTROL;
    wire wr_ctl = act_q && wr_q && idx_q == `IDX_TIMER_CONTROL;
    wire rd_unm = act_q && !wr_q && idx_q == 16'hfe20;
    // shadow of the address phase and of the edge settings software wrote
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            act_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 16'h0000;
            eic_q <= 8'h00;
        end else begin
            act_q <= taken;
            wr_q <= HWRITE_I;
            idx_q <= HADDR_I[17:2];
            if (wr_eic) eic_q <= HWDATA_I[7:0];
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    // rising edge on the fourth pin with rise select and enable set
    sequence s_rise_d;
        $rose(PORT_PIN_D_I) && eic_q[7] && eic_q[4] && !HOLD_I;
    endsequence
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus answer not ready okay");
    a_unmapped_zero: assert property (rd_unm |-> HRDATA_O == 32'h00000000)
        else $error("unmapped read not zero");
    a_filter_long: assert property (wr_sel && HWDATA_I[2:1] == 2'b01 |=>
        FILTER_CYCLES_O == 8'h80) else $error("filter long constant wrong");
    a_filter_mid: assert property (wr_sel && HWDATA_I[2:1] == 2'b11 |=>
        FILTER_CYCLES_O == 8'h20) else $error("filter mid constant wrong");
    a_filter_short: assert property (wr_sel && !HWDATA_I[1] |=>
        FILTER_CYCLES_O == 8'h01) else $error("filter short constant wrong");
    a_base_cycle: assert property (wr_sel && HWDATA_I[5:4] == 2'b01 |=>
        BASE_CLK_EN_O [*2]) else $error("base clock not cycle clock");
    a_irq3_sticky: assert property (IRQ3_REQ_O && !wr_eic |=> IRQ3_REQ_O)
        else $error("edge request dropped without write");
    a_timer_sticky: assert property (TIMER_LOW_REQ_O && !wr_ctl |=> TIMER_LOW_REQ_O)
        else $error("timer request dropped without write");
    a_hold_release: assert property (HOLD_RELEASE_O == IRQ2_REQ_O)
        else $error("hold release differs from request");
    a_irq3_rise: assert property (s_rise_d |-> ##[1:PIN_LAT] IRQ3_REQ_O)
        else $error("rising edge gave no request");
endmodule

bind timer0_capture timer0_capture_props #(.SYNC_STAGES(SYNC_STAGES)) i_timer0_capture_props (
    .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .PORT_PIN_D_I(PORT_PIN_D_I), .HOLD_I(HOLD_I), .IRQ3_REQ_O(IRQ3_REQ_O),
    .IRQ2_REQ_O(IRQ2_REQ_O), .HOLD_RELEASE_O(HOLD_RELEASE_O),
    .TIMER_LOW_REQ_O(TIMER_LOW_REQ_O), .BASE_CLK_EN_O(BASE_CLK_EN_O),
    .FILTER_CYCLES_O(FILTER_CYCLES_O));

/* File: pin_source.sv */
// model of the external signal sources on the two port pins
`timescale 1ns/100ps
module pin_source (
    // clock
    input wire logic clk_i,
    // pin levels
    output logic pin_c_o,
    output logic pin_d_o
);
    // pins rest low; a level stands until the next request
    initial begin
        pin_c_o = 1'b0;
        pin_d_o = 1'b0;
    end
    // slow sets how many cycles the source lags before it moves
    task automatic drive(input bit d, input bit lvl, input int slow);
        repeat (slow) @(posedge clk_i);
        @(posedge clk_i);
        if (d) pin_d_o <= lvl;
        else pin_c_o <= lvl;
    endtask
endmodule

/* File: timer0_capture_test.sv */
// self-checking bench for timer 0 with capture and port pin logic
`timescale 1ns/100ps
`include "timer0_cfg.svh"
module timer0_capture_test;
    // short aliases for the register indices
    localparam logic [15:0] CTL = `IDX_TIMER_CONTROL;
    localparam logic [15:0] PRR = `IDX_PRESCALER_MATCH;
    localparam logic [15:0] CL = `IDX_COUNT_LOW;
    localparam logic [15:0] MLO = `IDX_MATCH_LOW;
    localparam logic [15:0] MHI = `IDX_MATCH_HIGH;
    localparam logic [15:0] EIC = `IDX_EDGE_IRQ_CONTROL;
    localparam logic [15:0] SEL = `IDX_INPUT_SELECT;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic hold = 1'b0;
    logic sub_en = 1'b0;
    logic lassign = 1'b0;
    logic hassign = 1'b0;
    logic [5:0] det = 6'h00;
    logic [31:0] hrdata, rv;
    logic hready, hresp, pin_c, pin_d, irq3, irq2, hrel, treq_l, treq_h, bclk, buz;
    logic [7:0] filt;
    logic [7:0] fexp [4] = '{8'h01, 8'h80, 8'h01, 8'h20};
    logic [15:0] ids [8] = '{CTL, PRR, CL, MLO, MHI, EIC, SEL, 16'hfe20};
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t1, t2, t3;

    timer0_capture #(.SYNC_STAGES(2)) i_timer0_capture (
        .SYS_CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .PORT_PIN_C_I(pin_c), .PORT_PIN_D_I(pin_d), .FIRST_EXT_IRQ_DET_I(det[0]),
        .SECOND_EXT_IRQ_DET_I(det[1]), .BANK2_IRQ_A_DET_I(det[2]),
        .BANK2_IRQ_B_DET_I(det[3]), .BANK2_LCAP_ASSIGN_I(lassign),
        .BANK2_LCAP_DET_I(det[4]), .BANK2_HCAP_ASSIGN_I(hassign),
        .BANK2_HCAP_DET_I(det[5]), .HOLD_I(hold), .SUBCLK_EN_I(sub_en),
        .IRQ3_REQ_O(irq3), .IRQ2_REQ_O(irq2), .HOLD_RELEASE_O(hrel),
        .TIMER_LOW_REQ_O(treq_l), .TIMER_HIGH_REQ_O(treq_h), .BASE_CLK_EN_O(bclk),
        .BUZZER_SELECT_O(buz), .FILTER_CYCLES_O(filt));
    pin_source i_pin_source (.clk_i(clk), .pin_c_o(pin_c), .pin_d_o(pin_d));

    initial begin
        forever #10 clk = ~clk;
    end
    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single transfer; the read word is taken at the edge ending the data phase
    task automatic bus(input logic [15:0] idx, input bit w, input logic [7:0] d);
        @(posedge clk);
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rv = hrdata;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask
    task automatic rd(input string nm, input logic [15:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        chk(nm, {24'h000000, e}, rv);
    endtask
    // a pin change needs the sync stages before its flag shows
    task automatic pin(input bit d, input bit l, input int s);
        i_pin_source.drive(d, l, s);
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        det[b] <= 1'b1;
        @(posedge clk);
        det[b] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic rise(input bit h, output int t);
        int k = 0;
        @(posedge clk);
        while ((h ? treq_h : treq_l) !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        t = cyc;
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        // reset values, read-only and unmapped places
        foreach (ids[i]) rd("reset value", ids[i], 8'h00);
        wr(PRR, 8'h5a);
        rd("prescaler match", PRR, 8'h5a);
        wr(CL, 8'hff);
        rd("count low ro", CL, 8'h00);
        wr(16'hfe20, 8'hff);
        rd("unmapped", 16'hfe20, 8'h00);
        // filter constant and base clock for every code, prescaler matching each cycle
        wr(PRR, 8'h00);
        for (int c = 0; c < 4; c++) begin
            sub_en <= c[1];
            wr(SEL, {2'b00, c[1:0], 1'b0, c[1:0], 1'b0});
            @(posedge clk);
            chk("filter", {24'h000000, fexp[c]}, {24'h000000, filt});
            chk("base clock", {31'h0, c[0] | c[1]}, {31'h0, bclk});
        end
        // every edge select code on both pins, both edge directions, prompt and slow
        for (int q = 0; q < 2; q++)
            for (int s = 0; s < 4; s++)
                for (int l = 0; l < 2; l++) begin
                    pin(q, !l, 0);
                    wr(EIC, q ? {s[1:0], 6'h00} : {4'h0, s[1:0], 2'b00});
                    pin(q, l, s);
                    rd("edge flag", EIC, q ? {s[1:0], (l ? s[1] : s[0]), 5'h00} :
                        {4'h0, s[1:0], (l ? s[1] : s[0]), 1'b0});
                end
        // requests stand until software clears the flags
        wr(EIC, 8'hdd);
        pin(0, 0, 0);
        pin(1, 0, 0);
        repeat (20) @(posedge clk);
        chk("requests", 32'h7, {irq3, irq2, hrel});
        wr(EIC, 8'hdd);
        @(posedge clk);
        chk("cleared", 32'h0, {irq3, irq2, hrel});
        // hold entered with the third pin low: rise sets, fall is blocked
        wr(EIC, 8'h0c);
        hold <= 1'b1;
        pin(0, 1, 0);
        rd("hold rise", EIC, 8'h0e);
        wr(EIC, 8'h0c);
        pin(0, 0, 0);
        rd("hold fall", EIC, 8'h0c);
        hold <= 1'b0;
        // mode 0 low byte period, new match value taken only at a match
        wr(PRR, 8'h03);
        wr(MLO, 8'h04);
        wr(CTL, 8'h41);
        rise(0, t1);
        wr(MLO, 8'h01);
        wr(CTL, 8'h41);
        rise(0, t2);
        wr(CTL, 8'h41);
        rise(0, t3);
        chk("period", 32'd20, t2 - t1);
        chk("reload", 32'd8, t3 - t2);
        // mode 2 sixteen-bit period
        wr(CTL, 8'h00);
        wr(PRR, 8'h00);
        wr(MLO, 8'h02);
        wr(MHI, 8'h01);
        wr(CTL, 8'he4);
        rise(1, t1);
        wr(CTL, 8'he4);
        rise(1, t2);
        chk("16-bit period", 32'd259, t2 - t1);
        // mode 1 counting pin events, low captures and their sources
        wr(CTL, 8'h00);
        wr(MLO, 8'h10);
        wr(EIC, 8'h0c);
        wr(SEL, 8'h40);
        wr(CTL, 8'h50);
        pin(0, 1, 0);
        pin(0, 0, 1);
        rd("count", CL, 8'h02);
        pulse(0);
        rd("capture low", `IDX_CAPTURE0_LOW, 8'h02);
        pin(0, 1, 0);
        lassign <= 1'b1;
        pulse(0);
        rd("port capture", `IDX_CAPTURE0_LOW, 8'h02);
        pulse(4);
        rd("bank2 capture", `IDX_CAPTURE0_LOW, 8'h03);
        pulse(2);
        rd("capture1 low", `IDX_CAPTURE1_LOW, 8'h03);
        wr(EIC, 8'hdc);
        pin(1, 1, 0);
        rd("count source", CL, 8'h03);
        wr(SEL, 8'h41);
        pin(1, 0, 0);
        rd("count source", CL, 8'h04);
        // mode 3 pair captures
        wr(CTL, 8'h00);
        wr(CTL, 8'hf0);
        wr(SEL, 8'hc9);
        pin(1, 1, 0);
        pin(1, 0, 0);
        pulse(3);
        rd("pair1 low", `IDX_CAPTURE1_LOW, 8'h02);
        rd("pair1 high", `IDX_CAPTURE1_HIGH, 8'h00);
        pulse(1);
        rd("pair0 low", `IDX_CAPTURE0_LOW, 8'h02);
        chk("buzzer", 32'h1, {31'h0, buz});
        tally_and_finish();
    end
endmodule
